// ==== src/mlts_top.v ====
// maintenance loop-back test generator, result counters and status
// Behaviour
// R1: 8-bit pattern selector, center side only; other codes send nothing.
// R2: code 0 gives 64-byte unicast 55aa, code 1 gives 1518-byte unicast 55aa.
// R3: bit 2 alone gives 1518-byte broadcast 55aa frames.
// R4: bit 4 alone gives 1518-byte unicast 0f0f frames.
// R5: bit 6 alone gives 1518 broadcast 0f0f; bit 7 alone 1518 broadcast ff00.
// R6: bits 1, 3, 5 alone: 64-byte bcast 55aa, unicast 0f0f, bcast 0f0f.
// R7: unicast destination: station address, last byte +1, rising per frame.
// R8: source address is the six station address bytes unchanged.
// R9: every test frame carries type/length 0800.
// R10: center side counts returned frames with crc error, 8 bits, read only.
// R11: center side counts frames that never returned, 8 bits, read only.
// R12: center side counts frames that returned good, 8 bits, read only.
// R13: a zero write to the setup/count register clears all three counters.
// R14: result counters saturate at 255 instead of wrapping.
// R15: hardware version is read-only in status bits 7:6.
// R16: model version is writable in status bits 5:4; 00 short, 01 long reach.
// R17: status bit 3 flags a loop-stop indication; cleared when read.
// R18: status bit 2 flags loop-duration timer expiry; cleared when read.
// R19: status bit 1 flags reply-wait timer expiry; cleared when read.
// R20: status bit 0 shows live port-1 link loss, one when down.
// R21: center side sends 1 to 100 frames on a count write; default 7.
`timescale 1ns/1ps
`default_nettype none
`include "mlts_map.vh"

module mlts_top #(
    parameter [1:0] HW_VERSION = 2'h1, // arbitrary value
    parameter [31:0] REPLY_WAIT_CYCLES = 32'd50000,
    parameter [31:0] LOOP_DURATION_CYCLES = 32'd5000000
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // device mode and port state
    input wire maintenance_sublayer,
    input wire fiber_port_link_lost,
    // test frame stream toward the fiber mac
    input wire tx_ready,
    output wire tx_valid,
    output wire [7:0] tx_data,
    output wire tx_last,
    // returned frame events
    input wire rx_return,
    input wire rx_return_crc_err,
    input wire rx_loop_stop
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_SEND = 2'h1;
    localparam [1:0] S_WAIT = 2'h2;

    // software-visible state
    reg [7:0] setup_count_q;
    reg [7:0] pattern_sel_q;
    reg [7:0] crc_cnt_q;
    reg [7:0] to_cnt_q;
    reg [7:0] good_cnt_q;
    reg [1:0] model_ver_q;
    reg loop_stop_seen_q;
    reg loop_dur_exp_q;
    reg reply_to_q;
    reg [47:0] station_addr_q;

    // bus data-phase state
    reg wr_pend_q;
    reg [7:0] wr_idx_q;

    // sequencer state
    reg [1:0] state_q;
    reg [7:0] left_q;
    reg [7:0] da_last_q;
    reg [31:0] reply_tmr_q;
    reg [31:0] loop_tmr_q;
    reg gen_start_q;
    reg len_long_q;
    reg bcast_q;
    reg [15:0] payload_q;

    wire gen_busy;
    wire addr_ok = hsel & hready & htrans[1];
    wire [7:0] a_idx = haddr[9:2];
    wire rd_acc = addr_ok & ~hwrite;
    wire rd_status = rd_acc & (a_idx == `MLTS_IDX_ADD_STATUS);
    wire wr_now = wr_pend_q;
    wire [7:0] wbyte = hwdata[7:0];
    wire wr_count = wr_now & (wr_idx_q == `MLTS_IDX_SETUP_COUNT);
    wire clr_cnt = wr_count & (wbyte == 8'h00); // R13
    wire start_req = wr_count & (wbyte != 8'h00) &
        (wbyte <= `MLTS_MAX_FRAMES); // R21

    // pattern decode; pat_ok low for codes that are not applicable
    reg pat_ok;
    reg pat_long;
    reg pat_bcast;
    reg [15:0] pat_data;
    always @* begin
        pat_ok = 1'b1;
        pat_long = 1'b1;
        pat_bcast = 1'b0;
        pat_data = `MLTS_DATA_55AA;
        case (pattern_sel_q)
            `MLTS_PAT_0: pat_long = 1'b0; // R2
            `MLTS_PAT_1: pat_long = 1'b1; // R2
            `MLTS_PAT_2: begin
                pat_long = 1'b0; // R6
                pat_bcast = 1'b1;
            end
            `MLTS_PAT_3: pat_bcast = 1'b1; // R3
            `MLTS_PAT_4: begin
                pat_long = 1'b0; // R6
                pat_data = `MLTS_DATA_0F0F;
            end
            `MLTS_PAT_5: pat_data = `MLTS_DATA_0F0F; // R4
            `MLTS_PAT_6: begin
                pat_long = 1'b0; // R6
                pat_bcast = 1'b1;
                pat_data = `MLTS_DATA_0F0F;
            end
            `MLTS_PAT_7: begin
                pat_bcast = 1'b1; // R5
                pat_data = `MLTS_DATA_0F0F;
            end
            `MLTS_PAT_8: begin
                pat_bcast = 1'b1; // R5
                pat_data = `MLTS_DATA_FF00;
            end
            default: pat_ok = 1'b0; // R1
        endcase
    end

    // sequencer events
    wire active = (state_q != S_IDLE);
    wire waiting = (state_q == S_WAIT);
    wire got_ret = waiting & rx_return;
    wire got_crc = got_ret & rx_return_crc_err;
    wire got_good = got_ret & ~rx_return_crc_err;
    wire reply_exp = waiting & ~rx_return &
        (reply_tmr_q == REPLY_WAIT_CYCLES - 32'd1);
    wire loop_exp = active & (loop_tmr_q == LOOP_DURATION_CYCLES - 32'd1);
    wire stop_ind = maintenance_sublayer & rx_loop_stop;

    // ahb address phase: capture writes, register read data, zero wait
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= addr_ok & hwrite & (haddr[31:10] == 22'h000000);
            wr_idx_q <= a_idx;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            if (rd_acc && haddr[31:10] == 22'h000000) begin
                case (a_idx)
                    `MLTS_IDX_SETUP_COUNT: hrdata[7:0] <= setup_count_q;
                    `MLTS_IDX_PATTERN_SEL: hrdata[7:0] <= pattern_sel_q;
                    `MLTS_IDX_CRC_COUNT: hrdata[7:0] <= crc_cnt_q; // R10
                    `MLTS_IDX_TIMEOUT_COUNT: hrdata[7:0] <= to_cnt_q; // R11
                    `MLTS_IDX_GOOD_COUNT: hrdata[7:0] <= good_cnt_q; // R12
                    `MLTS_IDX_ADD_STATUS: hrdata[7:0] <= {HW_VERSION, // R15
                        model_ver_q, loop_stop_seen_q, loop_dur_exp_q,
                        reply_to_q, fiber_port_link_lost}; // R20
                    8'h52: hrdata[7:0] <= station_addr_q[47:40];
                    8'h53: hrdata[7:0] <= station_addr_q[39:32];
                    8'h54: hrdata[7:0] <= station_addr_q[31:24];
                    8'h55: hrdata[7:0] <= station_addr_q[23:16];
                    8'h56: hrdata[7:0] <= station_addr_q[15:8];
                    `MLTS_IDX_STATION_ADDR5: hrdata[7:0] <= station_addr_q[7:0];
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // writable registers, taken in the data phase
    integer k;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            setup_count_q <= `MLTS_RST_SETUP_COUNT; // R21
            pattern_sel_q <= `MLTS_RST_PATTERN_SEL;
            model_ver_q <= `MLTS_RST_MODEL_VER;
            station_addr_q <= 48'h000000000000;
        end else if (wr_now) begin
            if (wr_idx_q == `MLTS_IDX_SETUP_COUNT)
                setup_count_q <= wbyte;
            if (wr_idx_q == `MLTS_IDX_PATTERN_SEL)
                pattern_sel_q <= wbyte;
            if (wr_idx_q == `MLTS_IDX_ADD_STATUS)
                model_ver_q <= wbyte[`MLTS_ST_MODEL_HI:`MLTS_ST_MODEL_LO]; // R16
            for (k = 0; k < 6; k = k + 1) begin
                if (wr_idx_q == `MLTS_IDX_STATION_ADDR0 + k[7:0])
                    station_addr_q[47 - 8*k -: 8] <= wbyte;
            end
        end
    end

    // sticky status bits: a set in the read cycle wins over the clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_stop_seen_q <= 1'b0;
            loop_dur_exp_q <= 1'b0;
            reply_to_q <= 1'b0;
        end else begin
            loop_stop_seen_q <= stop_ind |
                (loop_stop_seen_q & ~rd_status); // R17
            loop_dur_exp_q <= loop_exp |
                (loop_dur_exp_q & ~rd_status); // R18
            reply_to_q <= reply_exp | (reply_to_q & ~rd_status); // R19
        end
    end

    // result counters; an event in the clearing cycle still counts as one
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_cnt_q <= 8'h00;
            to_cnt_q <= 8'h00;
            good_cnt_q <= 8'h00;
        end else begin
            if (clr_cnt)
                crc_cnt_q <= {7'h00, got_crc}; // R13
            else if (got_crc && crc_cnt_q != `MLTS_COUNT_MAX)
                crc_cnt_q <= crc_cnt_q + 8'h01; // R10 R14
            if (clr_cnt)
                to_cnt_q <= {7'h00, reply_exp}; // R13
            else if (reply_exp && to_cnt_q != `MLTS_COUNT_MAX)
                to_cnt_q <= to_cnt_q + 8'h01; // R11 R14
            if (clr_cnt)
                good_cnt_q <= {7'h00, got_good}; // R13
            else if (got_good && good_cnt_q != `MLTS_COUNT_MAX)
                good_cnt_q <= good_cnt_q + 8'h01; // R12 R14
        end
    end

    // sequencer: send one frame, wait for its return, repeat; a loop
    // stop or the loop-duration limit aborts the run, so a stuck far
    // end cannot hold the fiber in test traffic
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_IDLE;
            left_q <= 8'h00;
            da_last_q <= 8'h00;
            reply_tmr_q <= 32'h00000000;
            loop_tmr_q <= 32'h00000000;
            gen_start_q <= 1'b0;
            len_long_q <= 1'b0;
            bcast_q <= 1'b0;
            payload_q <= 16'h0000;
        end else begin
            gen_start_q <= 1'b0;
            loop_tmr_q <= active ? loop_tmr_q + 32'd1 : 32'h00000000;
            case (state_q)
                S_IDLE: begin
                    if (start_req && maintenance_sublayer && pat_ok) begin // R1
                        left_q <= wbyte; // R21
                        da_last_q <= station_addr_q[7:0] + 8'h01; // R7
                        len_long_q <= pat_long;
                        bcast_q <= pat_bcast;
                        payload_q <= pat_data;
                        gen_start_q <= 1'b1;
                        state_q <= S_SEND;
                    end
                end
                S_SEND: begin
                    // wait for the generator to take and finish the frame
                    if (!gen_start_q && !gen_busy) begin
                        reply_tmr_q <= 32'h00000000;
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    reply_tmr_q <= reply_tmr_q + 32'd1;
                    if (got_ret || reply_exp) begin
                        if (left_q == 8'h01) begin
                            state_q <= S_IDLE;
                        end else begin
                            left_q <= left_q - 8'h01;
                            da_last_q <= da_last_q + 8'h01; // R7
                            gen_start_q <= 1'b1;
                            state_q <= S_SEND;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
            if (loop_exp || (stop_ind && active)) begin
                state_q <= S_IDLE;
                gen_start_q <= 1'b0;
            end
        end
    end

    // frame byte generator
    mlts_frame_gen u_gen (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(gen_start_q),
        .len_long(len_long_q),
        .bcast(bcast_q),
        .payload(payload_q),
        .station_addr(station_addr_q),
        .da_last(da_last_q),
        .tx_ready(tx_ready),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_last(tx_last),
        .busy(gen_busy)
    );

endmodule
`default_nettype wire

// ==== src/mlts_map.vh ====
// register map, field positions, reset values and frame constants
`ifndef MLTS_MAP_VH
`define MLTS_MAP_VH

// register indexes; byte address is four times the index
`define MLTS_IDX_SETUP_COUNT 8'h44
`define MLTS_IDX_PATTERN_SEL 8'h45
`define MLTS_IDX_CRC_COUNT 8'h46
`define MLTS_IDX_TIMEOUT_COUNT 8'h47
`define MLTS_IDX_GOOD_COUNT 8'h48
`define MLTS_IDX_ADD_STATUS 8'h49
`define MLTS_IDX_STATION_ADDR0 8'h52
`define MLTS_IDX_STATION_ADDR5 8'h57

// reset values, frame count limit and counter maximum
`define MLTS_RST_SETUP_COUNT 8'h07
`define MLTS_RST_PATTERN_SEL 8'h00
`define MLTS_RST_MODEL_VER 2'h0
`define MLTS_MAX_FRAMES 8'h64
`define MLTS_COUNT_MAX 8'hff

// additional status field positions
`define MLTS_ST_HW_VER_HI 7
`define MLTS_ST_HW_VER_LO 6
`define MLTS_ST_MODEL_HI 5
`define MLTS_ST_MODEL_LO 4
`define MLTS_ST_LOOP_STOP 3
`define MLTS_ST_LOOP_DUR 2
`define MLTS_ST_REPLY_TO 1
`define MLTS_ST_LINK_LOST 0

// pattern selector codes
`define MLTS_PAT_0 8'h00
`define MLTS_PAT_1 8'h01
`define MLTS_PAT_2 8'h02
`define MLTS_PAT_3 8'h04
`define MLTS_PAT_4 8'h08
`define MLTS_PAT_5 8'h10
`define MLTS_PAT_6 8'h20
`define MLTS_PAT_7 8'h40
`define MLTS_PAT_8 8'h80

// payload words and frame layout (lengths exclude the 4-byte fcs)
`define MLTS_DATA_55AA 16'h55aa
`define MLTS_DATA_0F0F 16'h0f0f
`define MLTS_DATA_FF00 16'hff00
`define MLTS_TYPE_LEN 16'h0800
`define MLTS_LEN_SHORT 11'h03c
`define MLTS_LEN_LONG 11'h5ea
`define MLTS_HDR_LEN 11'h00e

`endif

// ==== src/mlts_frame_gen.v ====
// byte sequencer that emits one loop-back test frame
`timescale 1ns/1ps
`default_nettype none
`include "mlts_map.vh"

module mlts_frame_gen (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // frame request
    input wire start,
    input wire len_long,
    input wire bcast,
    input wire [15:0] payload,
    input wire [47:0] station_addr,
    input wire [7:0] da_last,
    // byte stream
    input wire tx_ready,
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg tx_last,
    output reg busy
);
    reg [10:0] idx_q;
    reg [10:0] len_q;
    reg bcast_q;
    reg [15:0] pay_q;
    reg [47:0] sa_q;
    reg [7:0] dal_q;
    reg [7:0] byte_d;
    wire [10:0] nxt = idx_q + 11'h001;
    wire [10:0] pofs = nxt - `MLTS_HDR_LEN;
    wire [15:0] tlen = `MLTS_TYPE_LEN;

    // byte for position nxt; fcs is appended by the mac behind us
    always @* begin
        byte_d = 8'h00;
        if (nxt < 11'h006) begin
            if (bcast_q)
                byte_d = 8'hff;
            else if (nxt == 11'h005)
                byte_d = dal_q; // R7
            else
                byte_d = sa_q[47 - 8*nxt[2:0] -: 8]; // R7
        end else if (nxt < 11'h00c) begin
            byte_d = sa_q[47 - 8*(nxt[3:0] - 4'h6) -: 8]; // R8
        end else if (nxt == 11'h00c) begin
            byte_d = tlen[15:8]; // R9
        end else if (nxt == 11'h00d) begin
            byte_d = tlen[7:0]; // R9
        end else begin
            byte_d = pofs[0] ? pay_q[7:0] : pay_q[15:8];
        end
    end

    // frame state; a new start is ignored while busy
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_q <= 11'h000;
            len_q <= 11'h000;
            bcast_q <= 1'b0;
            pay_q <= 16'h0000;
            sa_q <= 48'h000000000000;
            dal_q <= 8'h00;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
            busy <= 1'b0;
        end else if (!busy) begin
            if (start) begin
                len_q <= len_long ? `MLTS_LEN_LONG : `MLTS_LEN_SHORT;
                bcast_q <= bcast;
                pay_q <= payload;
                sa_q <= station_addr;
                dal_q <= da_last;
                idx_q <= 11'h000;
                busy <= 1'b1;
                tx_valid <= 1'b1;
                tx_data <= bcast ? 8'hff : station_addr[47:40];
                tx_last <= 1'b0;
            end
        end else if (tx_ready) begin
            if (tx_last) begin
                busy <= 1'b0;
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
            end else begin
                idx_q <= nxt;
                tx_data <= byte_d;
                tx_last <= (nxt == len_q - 11'h001);
            end
        end
    end

endmodule
`default_nettype wire

// ==== tb/mlts_term_model.sv ====
// terminal-side partner that sinks test frames and loops them back
`timescale 1ns/1ps
`default_nettype none
module mlts_term_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench control: mode 0 good, 1 crc error, 2 no return
    input wire logic [1:0] mode,
    input wire logic stall,
    input wire logic stop_req,
    // frame stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    // return events
    output logic rx_return,
    output logic rx_return_crc_err,
    output logic rx_loop_stop
);
    logic [7:0] hdr [0:17];
    logic [10:0] idx;
    logic [10:0] nbytes;
    logic [15:0] nframes;
    logic [2:0] dly;
    logic tgl;
    // stall drops ready every other cycle
    assign tx_ready = !stall || tgl;
    // capture header bytes; reply a few cycles after the last byte
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx <= 11'h000;
            nbytes <= 11'h000;
            nframes <= 16'h0000;
            dly <= 3'h0;
            tgl <= 1'b0;
            rx_return <= 1'b0;
            rx_return_crc_err <= 1'b0;
            rx_loop_stop <= 1'b0;
        end else begin
            tgl <= !tgl;
            rx_loop_stop <= stop_req;
            rx_return <= dly == 3'h1 && mode != 2'h2;
            // qualifier toggles when unused so no stale level is seen
            rx_return_crc_err <= dly == 3'h1 ? mode == 2'h1 : tgl;
            if (dly != 3'h0) begin
                dly <= dly - 3'h1;
            end
            if (tx_valid && tx_ready) begin
                if (idx < 11'd18) begin
                    hdr[idx] <= tx_data;
                end
                idx <= tx_last ? 11'h000 : idx + 11'h001;
                if (tx_last) begin
                    nbytes <= idx + 11'h001;
                    nframes <= nframes + 16'h0001;
                    dly <= 3'h4;
                end
            end else if (!tx_valid) begin
                idx <= 11'h000; // an aborted frame restarts the count
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/mlts_top_assertions.sv ====
// port-level checker for the loop-back test block
`timescale 1ns/1ps
`default_nettype none
module mlts_top_chk #(
    parameter [1:0] HW_VERSION = 2'h1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic maintenance_sublayer,
    input wire logic fiber_port_link_lost,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic acc;
    logic st_rd;
    logic [10:0] idx_q;
    logic [7:0] b1_q;
    logic [7:0] b2_q;
    assign acc = tx_valid && tx_ready;
    assign st_rd = hsel && hready && htrans[1] && !hwrite &&
        haddr == 32'h124;
    // byte index and the two bytes before it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_q <= 11'h000;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
        end else if (acc) begin
            idx_q <= tx_last ? 11'h000 : idx_q + 11'h001;
            b1_q <= tx_data;
            b2_q <= b1_q;
        end else if (!tx_valid) begin
            idx_q <= 11'h000;
        end
    end
    property p_center_only;
        $rose(tx_valid) |-> $past(maintenance_sublayer, 2);
    endproperty
    a_center_only: assert property (p_center_only)
        else $error("frame sent off center side");
    property p_len;
        acc && tx_last |-> (idx_q == 11'd59 || idx_q == 11'd1513);
    endproperty
    a_len: assert property (p_len)
        else $error("frame length wrong");
    property p_type;
        acc && idx_q[10:1] == 10'd6 |->
            tx_data == (idx_q[0] ? 8'h00 : 8'h08);
    endproperty
    a_type: assert property (p_type)
        else $error("type field wrong");
    property p_payload;
        acc && idx_q > 11'd15 |-> tx_data == b2_q;
    endproperty
    a_payload: assert property (p_payload)
        else $error("payload does not repeat");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte changed while stalled");
    property p_gap;
        acc && tx_last |=> !tx_valid;
    endproperty
    a_gap: assert property (p_gap)
        else $error("next frame without reply wait");
    property p_link;
        st_rd |=> hrdata[0] == $past(fiber_port_link_lost);
    endproperty
    a_link: assert property (p_link)
        else $error("link bit wrong");
    property p_hwver;
        st_rd |=> hrdata[7:6] == HW_VERSION;
    endproperty
    a_hwver: assert property (p_hwver)
        else $error("hardware version wrong");
endmodule
bind mlts_top mlts_top_chk #(.HW_VERSION(HW_VERSION)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .maintenance_sublayer(maintenance_sublayer),
    .fiber_port_link_lost(fiber_port_link_lost), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last)
);
`default_nettype wire

// ==== tb/mlts_top_tb_top.sv ====
// register-level bench for the loop-back test block
`timescale 1ns/1ps
`default_nettype none
module maint_loopback_test_status_tb_top;
    localparam logic [1:0] HWV = 2'h2;
    localparam logic [8:0] LONG = 9'b110101010;
    localparam logic [8:0] BC = 9'b111001100;
    logic hclk, hresetn, hwrite, ms, lnk, stall, stop_req;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, mode;
    logic hreadyout, hresp, tx_ready, tx_valid, tx_last;
    logic rx_return, rx_return_crc_err, rx_loop_stop;
    logic [7:0] tx_data, i;
    logic [7:0] sa [0:5] = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'hfe};
    logic [15:0] pl, t;
    int k, j, error_cnt, n_tests, cyc;
    mlts_top #(.HW_VERSION(HWV), .REPLY_WAIT_CYCLES(32'd20),
        .LOOP_DURATION_CYCLES(32'd8000)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .maintenance_sublayer(ms),
        .fiber_port_link_lost(lnk), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .rx_return(rx_return), .rx_return_crc_err(rx_return_crc_err),
        .rx_loop_stop(rx_loop_stop));
    mlts_term_model u_term (.hclk(hclk), .hresetn(hresetn), .mode(mode),
        .stall(stall), .stop_req(stop_req), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .rx_return(rx_return), .rx_return_crc_err(rx_return_crc_err),
        .rx_loop_stop(rx_loop_stop));
    always #10 hclk = ~hclk;
    task automatic print_verdict;
        $display("tests=%0d errors=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        haddr <= {22'h0, a, 2'b00};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hresp ? ~hrdata : hrdata; // an error response spoils the compare
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic wt(input logic [15:0] n);
        while (u_term.nframes != n) @(posedge hclk);
    endtask
    // run n frames; the settle time covers the reply wait
    task automatic frames(input logic [7:0] n);
        t = u_term.nframes + {8'h0, n};
        wr(8'h44, {24'h0, n});
        wt(t);
        repeat (30) @(posedge hclk);
    endtask
    task automatic nofrm(input logic [7:0] n);
        t = u_term.nframes;
        wr(8'h44, {24'h0, n});
        repeat (40) @(posedge hclk);
        chk(32'(u_term.nframes), 32'(t));
    endtask
    initial begin
        {hclk, hresetn, hwrite, lnk, stall, stop_req} = 6'h0;
        {haddr, hwdata, htrans, mode, cyc, error_cnt, n_tests} = 0;
        ms = 1'b1;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h44, 32'h07);
        rd(8'h45, 32'h00);
        rd(8'h49, {24'h0, HWV, 6'h00});
        wr(8'h40, 32'h5a);
        rd(8'h40, 32'h0);
        for (i = 8'h46; i < 8'h49; i++) begin
            wr(i, 32'hff);
            rd(i, 32'h0);
        end
        wr(8'h49, 32'hff);
        rd(8'h49, {24'h0, HWV, 6'h30});
        wr(8'h49, 32'h10);
        lnk <= 1'b1;
        rd(8'h49, {24'h0, HWV, 6'h11});
        lnk <= 1'b0;
        for (i = 0; i < 6; i++) wr(8'h52 + i, {24'h0, sa[i]});
        // last address byte wraps ff to 00
        t = u_term.nframes;
        wr(8'h44, 32'h2);
        wt(t + 16'h1);
        chk(32'(u_term.hdr[5]), 32'hff);
        wt(t + 16'h2);
        chk(32'(u_term.hdr[5]), 32'h00);
        repeat (30) @(posedge hclk);
        for (k = 0; k < 9; k++) begin
            stall <= k[0];
            pl = k < 4 ? 16'h55aa : k < 8 ? 16'h0f0f : 16'hff00;
            wr(8'h45, k == 0 ? 32'h0 : 32'h1 << (k - 1));
            frames(8'h1);
            chk(32'(u_term.nbytes), LONG[k] ? 32'd1514 : 32'd60);
            for (j = 0; j < 6; j++) begin
                if (BC[k] || j < 5)
                    chk(32'(u_term.hdr[j]), BC[k] ? 32'hff : 32'(sa[j]));
                chk(32'(u_term.hdr[j + 6]), 32'(sa[j]));
            end
            chk({u_term.hdr[12], u_term.hdr[13]}, 32'h0800);
            chk({u_term.hdr[14], u_term.hdr[15], u_term.hdr[16],
                u_term.hdr[17]}, {pl, pl});
        end
        rd(8'h48, 32'd11);
        wr(8'h45, 32'h0);
        mode <= 2'h1;
        frames(8'h3);
        rd(8'h46, 32'h3);
        mode <= 2'h2;
        frames(8'h2);
        rd(8'h47, 32'h2);
        rd(8'h49, {24'h0, HWV, 6'h12});
        rd(8'h49, {24'h0, HWV, 6'h10});
        mode <= 2'h0;
        stall <= 1'b0;
        wr(8'h44, 32'h0);
        for (i = 8'h46; i < 8'h49; i++) rd(i, 32'h0);
        frames(8'd100);
        frames(8'd100);
        frames(8'd56);
        rd(8'h48, 32'hff);
        stop_req <= 1'b1;
        @(posedge hclk);
        stop_req <= 1'b0;
        rd(8'h49, {24'h0, HWV, 6'h18});
        rd(8'h49, {24'h0, HWV, 6'h10});
        // stalled, unanswered frames outlive the loop timer
        {mode, stall} <= 3'h5;
        wr(8'h44, 32'd100);
        repeat (8300) @(posedge hclk);
        rd(8'h49, {24'h0, HWV, 6'h16});
        rd(8'h49, {24'h0, HWV, 6'h10});
        {mode, stall} <= 3'h0;
        ms <= 1'b0;
        nofrm(8'h1);
        ms <= 1'b1;
        wr(8'h45, 32'h3);
        nofrm(8'h1);
        wr(8'h45, 32'h0);
        nofrm(8'h65);
        rd(8'h44, 32'h65);
        print_verdict();
    end
endmodule
`default_nettype wire
